// file: src/nested_priority_interrupt_controller.sv
`timescale 1ns/1ps
// Functional notes
// - Serve the pending request with the highest software level.
// - On equal software level, the lowest vector index wins.
// - Unserved requests stay latched until entered or dropped by a peripheral clearing sequence.
// - Hardware order is unique, so exactly one winner results.
// - Reset and trap ignore current level; trap saves registers; level 3 loaded.
// - Reset and trap requests wake the core from HALT.
// - Trap instruction raises a request that outranks every maskable one.
// - Reset wins first; its routine runs at level 3.
// - Maskable served only if enabled and its level exceeds current level.
// - External pin groups wake the core from HALT.
// - Pin sensitivity is configurable; edge requests clear on entry.
// - Several pins of one group give one service of that vector.
// - Selected pins of a group are NANDed together.
// - Peripheral request needs its status flag and its enable both set.
// - Peripheral clearing sequence drops the latched request.
// - Any pending enabled source wakes the core from WAIT.
// - First service after HALT must be a HALT-capable source.
// - Other winners are served after that first service.
// - Nested or concurrent mode; no stack overflow flag.
// - Current level sits in condition code bits 5 and 3.
// - Entry loads the current level from the vector's priority field.
// - Core instructions may rewrite the priority bits.
// - Return from interrupt restores the stacked priority bits.
// - Writing the level 0 code into a priority field is ignored.
module nested_priority_interrupt_controller
	import irq_pkg::*;
#(
	parameter int PINS0 = 8,
	parameter int PINS1 = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [3:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  core_in_t              coreIn,
	output core_out_t             coreOut,
	output logic      [7:0]       ccOut,
	input  wire logic [PINS0-1:0] extPins0,
	input  wire logic [PINS1-1:0] extPins1,
	input  wire logic [NVEC-1:2]  periphFlag,
	input  wire logic [NVEC-1:2]  periphEn,
	input  wire logic [NVEC-1:2]  periphClr
);

	// Checked at elaboration; each group has one byte of select bits
	if (PINS0 < 1 || PINS0 > 8) begin : g_badPins0
		$error("extPins0 width must be 1 to 8");
	end
	if (PINS1 < 1 || PINS1 > 8) begin : g_badPins1
		$error("extPins1 width must be 1 to 8");
	end
	// Enable, pending and priority bytes are laid out for fourteen vectors
	if (NVEC != 14) begin : g_badVecCount
		$error("vector count must match the register map");
	end

	logic [PRIO_W-1:0] prio_r;
	logic [7:0]        cfg_r;
	logic [7:0]        sel0_r;
	logic [7:0]        sel1_r;
	logic [NVEC-1:0]   vecEn_r;
	logic [7:0]        cc_r;
	logic              ack_r;
	logic [31:0]       rdata_r;
	logic              trapPend_r;
	logic              resetPend_r;
	logic              haltFirst_r;
	core_out_t         out_r;

	logic              wrEn;
	logic              ack;
	logic [1:0]        curLevel;
	logic              nand0;
	logic              nand1;
	logic [NVEC-1:0]   reqIn;
	logic [NVEC-1:0]   clrSeq;
	logic [NVEC-1:0]   clrEntry;
	logic [NVEC-1:0]   pend;
	logic [NVEC-1:0]   elig;
	logic [1:0]        lvl [NVEC];
	logic              winReq;
	logic [3:0]        winIdx;
	logic [1:0]        winLvl;
	logic [1:0]        winCode;
	logic              found;
	logic [7:0]        rdMux;
	logic [NVEC-1:0]   armed;
	logic              mayPreempt;

	function automatic logic [1:0] levelOf(input logic [1:0] code);
		unique case (code)
			2'h2: levelOf = 2'h0;
			2'h1: levelOf = 2'h1;
			2'h0: levelOf = 2'h2;
			2'h3: levelOf = 2'h3;
		endcase
	endfunction

	// Avalon slave: one wait cycle, then the answer
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wrEn            = avs_write & ack_r;
	assign avs_readdata    = rdata_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read | avs_write) & ~ack_r;
	end

	// Unused bits read as zero; the top nibble of the last priority byte reads as ones
	always_comb begin
		rdMux = 8'h00;
		unique case (avs_address)
			4'h0:      rdMux = prio_r[7:0];
			4'h1:      rdMux = prio_r[15:8];
			4'h2:      rdMux = prio_r[23:16];
			RA_PRIO3:  rdMux = {4'hf, prio_r[27:24]};
			RA_CFG:    rdMux = cfg_r;
			RA_SEL0:   rdMux = sel0_r;
			RA_SEL1:   rdMux = sel1_r;
			RA_EN_LO:  rdMux = vecEn_r[7:0];
			RA_EN_HI:  rdMux = {2'h0, vecEn_r[13:8]};
			RA_CC:     rdMux = cc_r;
			RA_PND_LO: rdMux = pend[7:0];
			RA_PND_HI: rdMux = {2'h0, pend[13:8]};
			RA_STATUS: rdMux = {haltFirst_r, curLevel, out_r.req, out_r.vecIdx};
			default:   rdMux = 8'h00;
		endcase
	end

	// Data is captured in the wait cycle and stands while waitrequest is low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rdata_r <= 32'h00000000;
		else if (avs_read && !ack_r)
			rdata_r <= {24'h000000, rdMux};
	end

	// Priority fields; the two-bit code of vector i sits at bits 2i+1:2i
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prio_r <= PRIO_RST;
		end else if (wrEn && avs_address <= RA_PRIO3) begin
			for (int j = 0; j < 4; j++) begin
				if (8 * int'(avs_address[1:0]) + 2 * j < PRIO_W
				    && avs_writedata[2*j +: 2] != CODE_L0)
					prio_r[8 * int'(avs_address[1:0]) + 2 * j +: 2]
						<= avs_writedata[2*j +: 2];
			end
		end
	end

	// Select masks and sensing apply from the cycle after the write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r  <= CFG_RST;
			sel0_r <= SEL_RST;
			sel1_r <= SEL_RST;
		end else if (wrEn) begin
			if (avs_address == RA_CFG)
				cfg_r <= avs_writedata[7:0];
			if (avs_address == RA_SEL0)
				sel0_r <= avs_writedata[7:0];
			if (avs_address == RA_SEL1)
				sel1_r <= avs_writedata[7:0];
		end
	end

	// A disabled vector stays latched and is served once enabled again
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vecEn_r <= EN_RST;
		end else if (wrEn) begin
			if (avs_address == RA_EN_LO)
				vecEn_r[7:0] <= avs_writedata[7:0];
			if (avs_address == RA_EN_HI)
				vecEn_r[13:8] <= avs_writedata[5:0];
		end
	end

	// Level bits follow the winner on entry, else core, else bus
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cc_r <= CC_RST;
		end else if (ack) begin
			cc_r[CC_I1] <= out_r.newCode[1];
			cc_r[CC_I0] <= out_r.newCode[0];
		end else if (coreIn.ccWr) begin
			cc_r <= coreIn.ccWrData;
		end else if (wrEn && avs_address == RA_CC) begin
			cc_r <= avs_writedata[7:0];
		end
	end

	assign ccOut    = cc_r;
	assign curLevel = levelOf({cc_r[CC_I1], cc_r[CC_I0]});

	// Sources
	ext_pin_group #(
		.W(PINS0)
	) u_grp0 (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pins    (extPins0),
		.sel     (sel0_r[PINS0-1:0]),
		.nandOut (nand0)
	);

	ext_pin_group #(
		.W(PINS1)
	) u_grp1 (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pins    (extPins1),
		.sel     (sel1_r[PINS1-1:0]),
		.nandOut (nand1)
	);

	assign ack = coreIn.entryAck & out_r.req;

	always_comb begin
		reqIn  = '0;
		clrSeq = '0;
		reqIn[0] = nand0;
		reqIn[1] = nand1;
		for (int i = 2; i < NVEC; i++) begin
			reqIn[i]  = periphFlag[i] & periphEn[i];
			clrSeq[i] = periphClr[i];
		end
		for (int i = 0; i < NVEC; i++)
			clrEntry[i] = ack && out_r.vecIdx == 4'(i);
	end

	// Only the two pin groups have selectable sensing; peripherals are level
	for (genvar g = 0; g < NVEC; g++) begin : g_lat
		irq_req_latch u_lat (
			.mclk     (mclk),
			.rst_n    (rst_n),
			.sense    (g == 0 ? sense_t'(cfg_r[1:0])
			           : g == 1 ? sense_t'(cfg_r[3:2]) : SENSE_LEVEL),
			.reqIn    (reqIn[g]),
			.clrEntry (clrEntry[g]),
			.clrSeq   (clrSeq[g]),
			.pending  (pend[g])
		);
	end

	// Trap and reset requests; a new trap beats a clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			trapPend_r <= 1'b0;
		else
			trapPend_r <= coreIn.trapExec
			              | (trapPend_r & ~(ack && out_r.vecIdx == VEC_TRAP));
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			resetPend_r <= 1'b1;
		else if (ack && out_r.vecIdx == VEC_RESET)
			resetPend_r <= 1'b0;
	end

	// After HALT only wake-capable vectors compete until one is entered
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			haltFirst_r <= 1'b0;
		else if (coreIn.inHalt)
			haltFirst_r <= 1'b1;
		else if (ack)
			haltFirst_r <= 1'b0;
	end

	// Concurrent mode: maskables interrupt only main level; trap and reset still interrupt a running handler
	assign mayPreempt = cfg_r[CFG_NESTED] || curLevel == 2'h0;

	// Arbitration
	always_comb begin
		for (int i = 0; i < NVEC; i++) begin
			lvl[i]  = levelOf(prio_r[2*i +: 2]);
			elig[i] = pend[i] && vecEn_r[i] && lvl[i] > curLevel
			          && mayPreempt
			          && (!haltFirst_r || WAKE_CAP[i]);
		end
	end

	// Scan from lowest hardware order up; ties go to the lower index
	always_comb begin
		found   = 1'b0;
		winIdx  = 4'h0;
		winLvl  = 2'h0;
		winCode = CODE_L3;
		for (int i = NVEC - 1; i >= 0; i--) begin
			if (elig[i] && (!found || lvl[i] >= winLvl)) begin
				found   = 1'b1;
				winIdx  = 4'(i);
				winLvl  = lvl[i];
				winCode = prio_r[2*i +: 2];
			end
		end
		// Reset outranks trap; both ignore the current level and the enables
		if (trapPend_r) begin
			winIdx  = VEC_TRAP;
			winCode = CODE_L3;
		end
		if (resetPend_r) begin
			winIdx  = VEC_RESET;
			winCode = CODE_L3;
		end
		winReq = found | trapPend_r | resetPend_r;
	end

	// Wake-up looks at latched, enabled requests only; the current level is ignored,
	// since a halted core must resume before it can lower its level
	assign armed = pend & vecEn_r;

	// Request drops for the cycle after entry so the next winner is fresh
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= '0;
		end else begin
			out_r.req      <= winReq & ~ack;
			out_r.vecIdx   <= winIdx;
			out_r.saveRegs <= winIdx != VEC_RESET;
			out_r.newCode  <= winCode;
			out_r.wakeHalt <= |(armed & WAKE_CAP)
			                  | trapPend_r | resetPend_r;
			out_r.wakeWait <= |armed | trapPend_r | resetPend_r;
		end
	end

	assign coreOut = out_r;

endmodule

// file: src/irq_pkg.sv
package irq_pkg;

	localparam int NVEC = 14;
	localparam int PRIO_W = 2 * NVEC;

	// Vector indices beyond the maskable ones
	localparam logic [3:0] VEC_TRAP  = 4'he;
	localparam logic [3:0] VEC_RESET = 4'hf;

	// Vectors able to leave HALT
	localparam logic [NVEC-1:0] WAKE_CAP = 14'h002b;

	// Priority codes as {high bit, low bit}
	localparam logic [1:0] CODE_L0 = 2'h2;
	localparam logic [1:0] CODE_L3 = 2'h3;

	// Priority bit positions inside the condition code register
	localparam int CC_I1 = 5;
	localparam int CC_I0 = 3;

	// Values after reset
	localparam logic [7:0]        CC_RST   = 8'hea;
	localparam logic [PRIO_W-1:0] PRIO_RST = 28'hfffffff;
	localparam logic [7:0]        CFG_RST  = 8'h15;
	localparam logic [7:0]        SEL_RST  = 8'hff;
	localparam logic [NVEC-1:0]   EN_RST   = 14'h3fff;

	// Register word indices on the Avalon bus
	localparam logic [3:0] RA_PRIO0  = 4'h0;
	localparam logic [3:0] RA_PRIO3  = 4'h3;
	localparam logic [3:0] RA_CFG    = 4'h4;
	localparam logic [3:0] RA_SEL0   = 4'h5;
	localparam logic [3:0] RA_SEL1   = 4'h6;
	localparam logic [3:0] RA_EN_LO  = 4'h7;
	localparam logic [3:0] RA_EN_HI  = 4'h8;
	localparam logic [3:0] RA_CC     = 4'h9;
	localparam logic [3:0] RA_PND_LO = 4'ha;
	localparam logic [3:0] RA_PND_HI = 4'hb;
	localparam logic [3:0] RA_STATUS = 4'hc;

	// Configuration field positions
	localparam int CFG_NESTED = 4;

	typedef enum logic [1:0] {
		SENSE_LEVEL,
		SENSE_RISE,
		SENSE_FALL,
		SENSE_BOTH
	} sense_t;

	typedef struct packed {
		logic       entryAck;
		logic       trapExec;
		logic       ccWr;
		logic [7:0] ccWrData;
		logic       inHalt;
	} core_in_t;

	typedef struct packed {
		logic       req;
		logic [3:0] vecIdx;
		logic       saveRegs;
		logic [1:0] newCode;
		logic       wakeHalt;
		logic       wakeWait;
	} core_out_t;

endpackage

// file: src/ext_pin_group.sv
`timescale 1ns/1ps
module ext_pin_group
	import irq_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pins,
	input  wire logic [W-1:0] sel,
	output logic              nandOut
);

	if (W < 1 || W > 8) begin : g_badWidth
		$error("ext_pin_group: W must be 1 to 8");
	end

	logic [W-1:0] sync1_r;
	logic [W-1:0] sync2_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '1;
			sync2_r <= '1;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
		end
	end

	// Unselected pins count as high, so any one selected low pin raises the request
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			nandOut <= 1'b0;
		else
			nandOut <= ~&(sync2_r | ~sel);
	end

endmodule

// file: src/irq_req_latch.sv
`timescale 1ns/1ps
module irq_req_latch
	import irq_pkg::*;
(
	input  wire logic   mclk,
	input  wire logic   rst_n,
	input  sense_t      sense,
	input  wire logic   reqIn,
	input  wire logic   clrEntry,
	input  wire logic   clrSeq,
	output logic        pending
);

	logic prev_r;
	logic setEv;

	always_comb begin
		unique case (sense)
			SENSE_LEVEL: setEv = reqIn;
			SENSE_RISE:  setEv = reqIn & ~prev_r;
			SENSE_FALL:  setEv = ~reqIn & prev_r;
			SENSE_BOTH:  setEv = reqIn ^ prev_r;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			prev_r <= 1'b0;
		else
			prev_r <= reqIn;
	end

	// New event beats a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			pending <= 1'b0;
		else
			pending <= setEv | (pending & ~(clrEntry | clrSeq));
	end

endmodule

// file: tb/npic_checker.sv
`timescale 1ns/1ps
module npic_checker
	import irq_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input core_in_t        coreIn,
	input core_out_t       coreOut,
	input wire logic [7:0] ccOut
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire maskReq = coreOut.req && (coreOut.vecIdx < VEC_TRAP);
	wire nmReq   = coreOut.req && (coreOut.vecIdx >= VEC_TRAP);
	sequence take_s;
		coreIn.entryAck && coreOut.req;
	endsequence
	sequence one_wait_s;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	bus_wait_a: assert property (
		$rose(avs_read || avs_write) |-> one_wait_s)
		else $error("bus access wait not one cycle");
	reset_entry_a: assert property (
		nmReq && coreOut.vecIdx == VEC_RESET |-> !coreOut.saveRegs && coreOut.newCode == CODE_L3)
		else $error("reset entry wrong");
	trap_entry_a: assert property (
		nmReq && coreOut.vecIdx == VEC_TRAP |-> coreOut.saveRegs && coreOut.newCode == CODE_L3)
		else $error("trap entry wrong");
	entry_load_a: assert property (
		take_s |=> {ccOut[CC_I1], ccOut[CC_I0]} == $past(coreOut.newCode))
		else $error("level bits not loaded on entry");
	trap_answer_a: assert property (
		coreIn.trapExec |-> ##[1:4] (nmReq && coreOut.vecIdx == VEC_TRAP))
		else $error("trap not requested");
	mask_level_a: assert property (
		maskReq |-> $past({ccOut[CC_I1], ccOut[CC_I0]}) != CODE_L3)
		else $error("maskable request at level 3");
	halt_first_a: assert property (
		$past(coreIn.inHalt, 2) && maskReq |-> WAKE_CAP[coreOut.vecIdx])
		else $error("halt exit by incapable vector");
	wake_wait_a: assert property (
		maskReq |-> coreOut.wakeWait)
		else $error("no wait wakeup");
	nonmask_wake_a: assert property (
		nmReq |-> coreOut.wakeHalt)
		else $error("no halt wakeup");
endmodule

bind nested_priority_interrupt_controller npic_checker u_chk (
	.mclk(mclk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .coreIn(coreIn), .coreOut(coreOut), .ccOut(ccOut));

// file: tb/core_model.sv
`timescale 1ns/1ps
module core_model
	import irq_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  core_out_t       coreOut,
	input  wire logic [7:0] ccOut,
	input  wire logic [3:0] ackDelay,
	input  wire logic       trapGo,
	input  wire logic       haltGo,
	input  wire logic       iretGo,
	input  wire logic       ccGo,
	input  wire logic [7:0] ccData,
	output core_in_t        coreIn,
	output logic [3:0]      lastVec,
	output logic [7:0]      nEnt
);
	logic [7:0] stack [8];
	logic [2:0] sp;
	logic [3:0] cnt;
	logic       ack;
	logic       halt;
	// Return pops the stacked condition code back through the write path
	assign coreIn = '{entryAck: ack, trapExec: trapGo, ccWr: ccGo || iretGo,
		ccWrData: iretGo ? stack[sp - 3'h1] : ccData, inHalt: halt};
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			cnt <= 4'h0;
			sp <= 3'h0;
			nEnt <= 8'h0;
			halt <= 1'b0;
			lastVec <= 4'h0;
		end else begin
			ack <= 1'b0;
			// A halted core fetches nothing, so it acks only once woken
			if (coreOut.req && !ack && !halt) begin
				cnt <= (cnt == ackDelay) ? 4'h0 : cnt + 4'h1;
				ack <= (cnt == ackDelay);
			end
			if (ack && coreOut.req) begin
				lastVec <= coreOut.vecIdx;
				nEnt <= nEnt + 8'h1;
				if (coreOut.saveRegs) begin
					stack[sp] <= ccOut;
					sp <= sp + 3'h1;
				end
			end
			if (iretGo) begin
				sp <= sp - 3'h1;
			end
			halt <= haltGo || (halt && !coreOut.wakeHalt);
		end
	end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import irq_pkg::*;
;
	logic            mclk = 1'b0;
	logic            rst_n = 1'b0;
	logic            rd = 1'b0;
	logic            wr = 1'b0;
	logic [3:0]      addr = 4'h0;
	logic [31:0]     wdata = 32'h0;
	logic [31:0]     rdata;
	logic [31:0]     q;
	logic            wreq;
	logic [7:0]      pins0 = 8'hff;
	logic [7:0]      pins1 = 8'hff;
	logic [NVEC-1:2] pFlag = 12'h0;
	logic [NVEC-1:2] pEn = 12'h0;
	logic [NVEC-1:2] pClr = 12'h0;
	logic [3:0]      ackDelay = 4'h0;
	logic            trapGo = 1'b0;
	logic            haltGo = 1'b0;
	logic            iretGo = 1'b0;
	logic            ccGo = 1'b0;
	logic [7:0]      ccData = 8'h0;
	logic [3:0]      lastVec;
	logic [7:0]      nEnt;
	logic [7:0]      ccOut;
	core_in_t        coreIn;
	core_out_t       coreOut;
	int              n_errors = 0;
	int              tests_run = 0;
	always #12.5 mclk = ~mclk;
	nested_priority_interrupt_controller DUT (.mclk(mclk), .rst_n(rst_n), .avs_address(addr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .coreIn(coreIn), .coreOut(coreOut), .ccOut(ccOut),
		.extPins0(pins0), .extPins1(pins1), .periphFlag(pFlag), .periphEn(pEn),
		.periphClr(pClr));
	core_model core (.mclk(mclk), .rst_n(rst_n), .coreOut(coreOut), .ccOut(ccOut),
		.ackDelay(ackDelay), .trapGo(trapGo), .haltGo(haltGo), .iretGo(iretGo), .ccGo(ccGo),
		.ccData(ccData), .coreIn(coreIn), .lastVec(lastVec), .nEnt(nEnt));
	task automatic end_of_test();
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		n_errors++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) fail($sformatf("got %h want %h", g, e));
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int i;
		@(posedge mclk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		i = 0;
		do begin
			@(negedge mclk);
			i++;
		end while (wreq !== 1'b0 && i < 40);
		if (wreq !== 1'b0) begin
			fail("bus timeout");
			end_of_test();
		end
		@(posedge mclk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h0);
		chk(q, {24'h0, e});
	endtask
	task automatic cmd(input logic [3:0] k, input logic [7:0] d);
		@(posedge mclk);
		{ccGo, iretGo, haltGo, trapGo} <= k;
		ccData <= d;
		@(posedge mclk);
		{ccGo, iretGo, haltGo, trapGo} <= 4'h0;
	endtask
	task automatic expVec(input logic [3:0] v);
		int i;
		logic [7:0] n;
		n = nEnt;
		for (i = 0; i < 200 && nEnt === n; i++) @(negedge mclk);
		if (nEnt === n) begin
			fail("no entry");
			end_of_test();
		end
		tests_run++;
		if (lastVec !== v) fail($sformatf("vector %h want %h", lastVec, v));
	endtask
	// Source drops in the same cycle as the clear is raised, since a set beats a clear
	task automatic done(input int v);
		@(posedge mclk);
		pFlag[v] <= 1'b0;
		pClr[v] <= 1'b1;
		@(posedge mclk);
		pClr[v] <= 1'b0;
		cmd(4'h4, 8'h0);
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		expVec(VEC_RESET);
		chk(ccOut, CC_RST);
		rdChk(RA_PRIO0, PRIO_RST[7:0]);
		rdChk(RA_CFG, CFG_RST);
		rdChk(RA_SEL0, SEL_RST);
		rdChk(RA_EN_LO, EN_RST[7:0]);
		rdChk(4'hf, 8'h00);
		bus(1'b1, RA_PRIO0, 8'hcf);
		bus(1'b1, RA_PRIO0, 8'h64);
		rdChk(RA_PRIO0, 8'h44);
		cmd(4'h1, 8'h0);
		expVec(VEC_TRAP);
		cmd(4'h4, 8'h0);
		@(negedge mclk);
		chk(ccOut, CC_RST);
		cmd(4'h8, 8'he2);
		@(negedge mclk);
		chk(ccOut, 8'he2);
		ackDelay <= 4'h3;
		bus(1'b1, RA_PRIO0, 8'h3f);
		bus(1'b1, RA_PRIO0 + 4'h1, 8'hf1);
		pFlag[6:3] <= 4'hf;
		pEn[5:3] <= 3'h7;
		expVec(4'h3);
		chk({ccOut[CC_I1], ccOut[CC_I0]}, 2'h0);
		done(3);
		expVec(4'h5);
		done(5);
		expVec(4'h4);
		done(4);
		ackDelay <= 4'h0;
		bus(1'b1, RA_PRIO0, 8'h3d);
		bus(1'b1, RA_PRIO0 + 4'h1, 8'hf3);
		cmd(4'h2, 8'h0);
		pFlag[4] <= 1'b1;
		@(posedge mclk);
		pins0 <= 8'hdb;
		expVec(4'h0);
		expVec(4'h4);
		done(4);
		cmd(4'h4, 8'h0);
		// Level sensing on group 0, concurrent mode: no preemption of a running handler
		bus(1'b1, RA_CFG, 8'h00);
		expVec(4'h0);
		@(posedge mclk);
		pFlag[3] <= 1'b1;
		rdChk(RA_PND_LO, 8'h09);
		rdChk(RA_STATUS, 8'h20);
		pins0 <= 8'hff;
		cmd(4'h4, 8'h0);
		expVec(4'h3);
		done(3);
		expVec(4'h0);
		cmd(4'h4, 8'h0);
		rdChk(RA_PND_LO, 8'h00);
		end_of_test();
	end
endmodule
